// ### bench/acr_ctrl_monitor.sv
// Port checker for the converter control block.
`timescale 1ns/1ns
`include "acr_regs.vh"
module acr_ctrl_monitor
(
  // Clock and reset.
  input wire sys_clk,
  input wire srst,
  // Register port.
  input wire [31:0] addr,
  input wire wr_en,
  input wire rd_en,
  input wire [31:0] wdata,
  input wire [31:0] rdata,
  input wire addr_err,
  // Converter side.
  input wire [15:0] filt_data,
  input wire [15:0] cal_data,
  input wire analog_power,
  input wire mic_power,
  input wire dma_enable,
  input wire busy,
  input wire [31:0] settings,
  input wire irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Counts busy cycles so a cut-short conversion is caught.
  reg [15:0] busy_cnt_r;
  always @(posedge sys_clk)
  begin
    if (srst || !busy)
      busy_cnt_r <= 16'h0000;
    else
      busy_cnt_r <= busy_cnt_r + 16'h0001;
  end
  // A write to the command word.
  sequence cmd_wr;
    wr_en && addr == `ACR_BASE_ADDR;
  endsequence
  a_block_decode: assert property ((wr_en || rd_en) |=> addr_err == ($past(addr[31:8]) != 24'h408000))
    else $error("decode flag wrong");
  a_trigger_starts: assert property (cmd_wr ##0 (wdata[2] && wdata[0] && wdata[8:3] == 6'h00 && !busy) |=> ##1 busy)
    else $error("trigger did not start");
  a_mic_no_power: assert property (mic_power |-> !analog_power)
    else $error("power on in mic mode");
  a_mic_no_trigger: assert property (cmd_wr ##0 (wdata[8] && !busy) |=> ##1 !busy)
    else $error("trigger ran in mic mode");
  a_stop_clears: assert property (cmd_wr ##0 wdata[4] |=> !analog_power && !mic_power && !dma_enable)
    else $error("stop left bits set");
  a_soft_reset: assert property (cmd_wr ##0 wdata[3] |=> settings == `ACR_RST_SET && !busy)
    else $error("soft reset incomplete");
  a_settings_locked: assert property (busy && wr_en && addr == `ACR_BASE_ADDR + 32'h4 |=> $stable(settings))
    else $error("settings changed while busy");
  a_cmd_readback: assert property (rd_en && addr == `ACR_BASE_ADDR |=> rdata[31:10] == 22'h0 && !rdata[6] && rdata[4:3] == 2'h0)
    else $error("self-clearing or reserved bit read high");
  a_mode_bits: assert property (cmd_wr ##0 wdata[4:3] == 2'h0 |=> mic_power == $past(wdata[8]) && dma_enable == $past(wdata[9]))
    else $error("mode bits not taken");
  a_wake_length: assert property ($fell(busy) && !$past(wr_en) |-> busy_cnt_r >= 16'h0298)
    else $error("conversion too short");
endmodule // acr_ctrl_monitor
bind acr_ctrl acr_ctrl_monitor acr_ctrl_monitor_i (.sys_clk(sys_clk), .srst(srst), .addr(addr),
  .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata), .rdata(rdata), .addr_err(addr_err),
  .filt_data(filt_data), .cal_data(cal_data), .analog_power(analog_power),
  .mic_power(mic_power), .dma_enable(dma_enable), .busy(busy), .settings(settings), .irq(irq));

// ### bench/tb.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ns
`include "acr_regs.vh"
module tb;
  reg sys_clk = 1'b0;
  reg srst = 1'b1;
  reg [31:0] addr = 32'h0;
  reg wr_en = 1'b0;
  reg rd_en = 1'b0;
  reg [31:0] wdata = 32'h0;
  reg [15:0] filt_data = 16'h1234;
  reg [15:0] cal_data = 16'h0010;
  wire [31:0] rdata;
  wire [31:0] settings;
  wire addr_err, analog_power, mic_power, dma_enable, busy, irq;
  integer n_errors = 0;
  integer cmp_count = 0;
  integer i;
  // Clock of 100 MHz.
  always #5 sys_clk = ~sys_clk;
  acr_ctrl acr_ctrl_i (.sys_clk(sys_clk), .srst(srst), .addr(addr), .wr_en(wr_en),
    .rd_en(rd_en), .wdata(wdata), .rdata(rdata), .addr_err(addr_err), .filt_data(filt_data),
    .cal_data(cal_data), .analog_power(analog_power), .mic_power(mic_power),
    .dma_enable(dma_enable), .busy(busy), .settings(settings), .irq(irq));
  // Prints the counts and the verdict, then stops.
  task end_sim;
  begin
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  // Compares a value and counts the outcome.
  task chk(input [31:0] got, input [31:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  // Writes one word at an offset from the base; lets an edge pass first.
  task wr(input [31:0] o, input [31:0] d);
  begin
    @(posedge sys_clk);
    #1 addr = `ACR_BASE_ADDR + o;
    wdata = d;
    wr_en = 1'b1;
    @(posedge sys_clk);
    #1 wr_en = 1'b0;
  end
  endtask
  // Reads one word and compares it with the expected value.
  task rd(input [31:0] o, input [31:0] e);
  begin
    @(posedge sys_clk);
    #1 addr = `ACR_BASE_ADDR + o;
    rd_en = 1'b1;
    @(posedge sys_clk);
    #1 rd_en = 1'b0;
    chk(rdata, e);
  end
  endtask
  // Waits for the sequencer to start and then go idle, with bounds.
  task wait_idle;
  begin
    i = 0;
    while (busy !== 1'b1 && i < 10)
    begin
      @(posedge sys_clk);
      #1 i = i + 1;
    end
    if (i >= 10)
    begin
      n_errors = n_errors + 1;
      end_sim;
    end
    i = 0;
    while (busy !== 1'b0 && i < 2000)
    begin
      @(posedge sys_clk);
      #1 i = i + 1;
    end
    if (i >= 2000)
    begin
      n_errors = n_errors + 1;
      end_sim;
    end
  end
  endtask
  // Main sequence of tests.
  initial
  begin
    repeat (10) @(posedge sys_clk);
    #1 srst = 1'b0;
    rd(32'h0, 32'h0);
    rd(32'h4, 32'hC);
    rd(32'h8, 32'h0);
    rd(32'hC, 32'hF);
    rd(32'h10, 32'h0);
    rd(32'h14, 32'h0);
    rd(32'h18, 32'h0);
    rd(32'h20, 32'h0);
    rd(32'h24, 32'h0FFFFFFF);
    rd(32'h28, 32'h0);
    rd(32'h1C, 32'h0);
    wr(32'h100, 32'h0);
    chk({31'h0, addr_err}, 32'h1);
    $display("test reset values done");
    wr(32'hC, 32'h0);
    wr(32'h0, 32'h5);
    wait_idle;
    rd(32'h14, {filt_data, 16'h0});
    rd(32'h10, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(32'hC, 32'hF);
    rd(32'h8, 32'h0);
    rd(32'h10, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(32'h20, 32'h7);
    rd(32'h20, 32'h0);
    wr(32'hC, 32'h0);
    $display("test conversion done");
    wr(32'h24, 32'h7FFFFFFF);
    wr(32'h0, 32'hA7);
    wr(32'h4, 32'h800);
    wait_idle;
    rd(32'h4, 32'hC);
    rd(32'h18, {cal_data, 16'h0});
    rd(32'h14, {filt_data - cal_data, 16'h0});
    rd(32'h20, 32'h7);
    rd(32'h0, 32'hA3);
    wr(32'h0, 32'h0);
    rd(32'h0, 32'h2);
    wr(32'h0, 32'h40);
    rd(32'h0, 32'h0);
    $display("test calibration done");
    wr(32'h4, 32'h800);
    rd(32'h4, 32'h800);
    wr(32'h0, 32'h8);
    rd(32'h4, 32'hC);
    rd(32'h24, 32'h0FFFFFFF);
    rd(32'h14, 32'h0);
    rd(32'h18, {cal_data, 16'h0});
    rd(32'h0, 32'h0);
    $display("test soft reset done");
    wr(32'h0, 32'h201);
    chk({28'h0, busy, mic_power, analog_power, dma_enable}, 32'h3);
    wr(32'h0, 32'h10);
    chk({28'h0, busy, mic_power, analog_power, dma_enable}, 32'h0);
    wr(32'h0, 32'h305);
    chk({28'h0, busy, mic_power, analog_power, dma_enable}, 32'h5);
    wr(32'h0, 32'h10);
    chk({28'h0, busy, mic_power, analog_power, dma_enable}, 32'h0);
    rd(32'h0, 32'h0);
    $display("test modes and stop done");
    end_sim;
  end
endmodule // tb

// ### hw/acr_ctrl.v
// Converter control register block with conversion sequencer.
// Contract
// - Registers decode relative to the fixed peripheral base address.
// - Bit 0 powers analog subsystem; must be set before requesting conversion.
// - Writing one to bit 2 starts the conversion phase.
// - Power and trigger bits have no effect in microphone mode.
// - Calibration runs only when bits 1 and 7 are both set.
// - Calibration result goes to upper or lower offset field by bypass.
// - Writing zero to calibration request does not clear it.
// - Calibration cancel clears the request and always reads zero.
// - Bit 3 resets command, settings, result and limits; reads zero.
// - Bit 4 stops conversion, clears trigger, power, DMA, mic bits.
// - Window enable raises window hit flag when result within limits.
// - Bit 8 powers microphone mode; bit 9 enables DMA.
// - Result register at 0x14 presents two's complement result.
// - Offset correction register resets to zero and corrects data.
// - Interrupt mask resets to 0xF and masks interrupt sources.
// - Masked status is raw status filtered by the mask.
// - Raw status reports sources regardless of mask.
// - Upper limit resets to 0xFFFFFFF, lower to zero.
// - Each triggered acquisition starts with a six microsecond wake-up; continuous-mode repeats go straight to acquisition.
// - Busy set during conversion; settings writes blocked meanwhile.
// - End of calibration raises done flag and stores offset.
// - End of conversion stores compensated result and raises flag.
`timescale 1ns/1ns
`include "acr_regs.vh"
module acr_ctrl
(
  // Clock and reset.
  input wire sys_clk,
  input wire srst,
  // Register port.
  input wire [31:0] addr,
  input wire wr_en,
  input wire rd_en,
  input wire [31:0] wdata,
  output reg [31:0] rdata,
  output reg addr_err,
  // Analog front end and filter.
  input wire [15:0] filt_data,
  input wire [15:0] cal_data,
  output wire analog_power,
  output wire mic_power,
  output wire dma_enable,
  output wire busy,
  output wire [31:0] settings,
  // Interrupt.
  output wire irq
);
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_WAKE = 5'h02;
  localparam [4:0] S_CAL = 5'h04;
  localparam [4:0] S_ACQ = 5'h08;
  localparam [4:0] S_DONE = 5'h10;
  localparam [12:0] WAKE_CYC = `ACR_WAKE_CYC;
  localparam [12:0] ACQ_CYC = `ACR_ACQ_CYC;
  localparam [12:0] CAL_CYC = `ACR_CAL_CYC;

  reg [31:0] cmd_r;
  reg [31:0] set_r;
  reg [31:0] mask_r;
  reg [31:0] raw_r;
  reg [31:0] res_r;
  reg [31:0] ofs_r;
  reg [31:0] hi_r;
  reg [31:0] lo_r;
  reg [4:0] state_r;
  reg [12:0] cnt_r;
  reg [4:0] state_nxt;
  reg [12:0] cnt_nxt;
  reg [31:0] cmd_nxt;
  reg [31:0] sres;
  reg [15:0] sofs;
  wire in_block;
  wire [7:0] off;
  wire we_cmd;
  wire bypass;
  wire mic_mode;
  wire cal_on;
  wire start;
  wire soft_rst;
  wire stop;
  wire win_hit;
  wire eoc_ev;
  wire cal_ev;
  wire [31:0] comp;

  // Returns true when a write strikes the given offset.
  function hitw;
    input [7:0] o;
    input [7:0] t;
    input w;
    begin
      hitw = w && (o == t);
    end
  endfunction

  // Offset decode against the fixed base address.
  assign in_block = ({8'h00, addr[31:8]} == (`ACR_BASE_ADDR >> 8));
  assign off = addr[7:0];
  assign we_cmd = hitw(off, `ACR_OFF_CMD, wr_en && in_block);
  assign soft_rst = we_cmd && wdata[`ACR_CMD_SRST];
  assign stop = we_cmd && wdata[`ACR_CMD_STOP];
  assign bypass = set_r[`ACR_SET_BYPASS];
  assign mic_mode = cmd_r[`ACR_CMD_MICPWR];
  assign cal_on = cmd_r[`ACR_CMD_CALREQ] && cmd_r[`ACR_CMD_TRIM];
  // Trigger counts only with power on and not in microphone mode.
  assign start = cmd_r[`ACR_CMD_TRIG] && cmd_r[`ACR_CMD_POWER] && !mic_mode;
  assign analog_power = cmd_r[`ACR_CMD_POWER] && !mic_mode;
  assign mic_power = cmd_r[`ACR_CMD_MICPWR];
  assign dma_enable = cmd_r[`ACR_CMD_DMAEN];
  assign busy = !state_r[0];
  assign settings = set_r;
  assign eoc_ev = state_r[4];
  assign cal_ev = state_r[2] && (cnt_r == 13'h0001);

  // Offset-compensated result in the field chosen by bypass.
  always @*
  begin
    sofs = bypass ? ofs_r[15:0] : ofs_r[31:16];
    sres = {16'h0000, filt_data} - {16'h0000, sofs};
    if (!bypass)
      sres = {sres[15:0], 16'h0000};
  end
  assign comp = sres;

  acr_window u_win
  (
    .value(comp),
    .lower(lo_r),
    .upper(hi_r),
    .enable(cmd_r[`ACR_CMD_WINEN]),
    .hit(win_hit)
  );

  // Sequencer next state: wake, optional calibration, acquisition, done.
  always @*
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      S_IDLE:
      begin
        if (start)
        begin
          state_nxt = S_WAKE;
          cnt_nxt = WAKE_CYC;
        end
      end
      S_WAKE:
      begin
        if (cnt_r == 13'h0001)
        begin
          state_nxt = cal_on ? S_CAL : S_ACQ;
          cnt_nxt = cal_on ? CAL_CYC : ACQ_CYC;
        end
        else
          cnt_nxt = cnt_r - 13'h0001;
      end
      S_CAL:
      begin
        if (cnt_r == 13'h0001)
        begin
          state_nxt = S_ACQ;
          cnt_nxt = ACQ_CYC;
        end
        else
          cnt_nxt = cnt_r - 13'h0001;
      end
      S_ACQ:
      begin
        if (cnt_r == 13'h0001)
          state_nxt = S_DONE;
        else
          cnt_nxt = cnt_r - 13'h0001;
      end
      S_DONE:
      begin
        if (set_r[`ACR_SET_CONT] && analog_power)
        begin
          state_nxt = S_ACQ;
          cnt_nxt = ACQ_CYC;
        end
        else
          state_nxt = S_IDLE;
      end
      default:
      begin
        state_nxt = S_IDLE;
        cnt_nxt = 13'h0000;
      end
    endcase
    if (stop || soft_rst)
      state_nxt = S_IDLE;
  end

  // Command register next value with sticky and self-clearing bits.
  always @*
  begin
    cmd_nxt = cmd_r;
    if (we_cmd)
    begin
      cmd_nxt = wdata & `ACR_CMD_MASKW;
      cmd_nxt[`ACR_CMD_CALREQ] = cmd_r[`ACR_CMD_CALREQ] | wdata[`ACR_CMD_CALREQ];
      if (wdata[`ACR_CMD_CALCAN])
        cmd_nxt[`ACR_CMD_CALREQ] = 1'b0;
      cmd_nxt[`ACR_CMD_CALCAN] = 1'b0;
      cmd_nxt[`ACR_CMD_SRST] = 1'b0;
      cmd_nxt[`ACR_CMD_STOP] = 1'b0;
      if (wdata[`ACR_CMD_STOP])
      begin
        cmd_nxt[`ACR_CMD_TRIG] = 1'b0;
        cmd_nxt[`ACR_CMD_POWER] = 1'b0;
        cmd_nxt[`ACR_CMD_DMAEN] = 1'b0;
        cmd_nxt[`ACR_CMD_MICPWR] = 1'b0;
      end
    end
    else if (state_r[0] && start)
      cmd_nxt[`ACR_CMD_TRIG] = 1'b0;
  end

  // Register state update.
  always @(posedge sys_clk)
  begin
    if (srst || soft_rst)
    begin
      cmd_r <= `ACR_RST_CMD;
      set_r <= `ACR_RST_SET;
      res_r <= 32'h00000000;
      hi_r <= `ACR_RST_HI;
      lo_r <= `ACR_RST_LO;
      state_r <= S_IDLE;
      cnt_r <= 13'h0000;
    end
    else
    begin
      cmd_r <= cmd_nxt;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      if (hitw(off, `ACR_OFF_SET, wr_en && in_block) && state_r[0])
        set_r <= wdata;
      if (hitw(off, `ACR_OFF_HI, wr_en && in_block))
        hi_r <= wdata;
      if (hitw(off, `ACR_OFF_LO, wr_en && in_block))
        lo_r <= wdata;
      if (eoc_ev)
        res_r <= comp;
    end
    if (srst)
    begin
      mask_r <= `ACR_RST_MASK;
      ofs_r <= `ACR_RST_OFS;
      raw_r <= 32'h00000000;
    end
    else
    begin
      if (hitw(off, `ACR_OFF_MASK, wr_en && in_block))
        mask_r <= wdata;
      if (cal_ev)
      begin
        if (bypass)
          ofs_r <= {ofs_r[31:16], cal_data};
        else
          ofs_r <= {cal_data, ofs_r[15:0]};
      end
      else if (hitw(off, `ACR_OFF_OFS, wr_en && in_block))
        ofs_r <= wdata;
      // Flags: write one to the status word clears; a new event wins.
      if (hitw(off, `ACR_OFF_STAT, wr_en && in_block))
        raw_r <= raw_r & ~wdata;
      if (eoc_ev)
        raw_r[`ACR_IRQ_EOC] <= 1'b1;
      if (cal_ev)
        raw_r[`ACR_IRQ_CAL] <= 1'b1;
      if (eoc_ev && win_hit)
        raw_r[`ACR_IRQ_WIN] <= 1'b1;
    end
  end

  // A set mask bit blocks its source.
  assign irq = |(raw_r[2:0] & ~mask_r[2:0]);

  // Registered read data and unmapped-address flag.
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      rdata <= 32'h00000000;
      addr_err <= 1'b0;
    end
    else
    begin
      addr_err <= (rd_en || wr_en) && !in_block;
      if (rd_en)
      begin
        case (off)
          `ACR_OFF_CMD: rdata <= cmd_r & `ACR_CMD_MASKW;
          `ACR_OFF_SET: rdata <= set_r;
          `ACR_OFF_MSTAT: rdata <= {29'h0, raw_r[2:0] & ~mask_r[2:0]};
          `ACR_OFF_MASK: rdata <= mask_r;
          `ACR_OFF_RAW: rdata <= {29'h0, raw_r[2:0]};
          `ACR_OFF_RES: rdata <= res_r;
          `ACR_OFF_OFS: rdata <= ofs_r;
          `ACR_OFF_STAT: rdata <= {28'h0, busy, raw_r[2:0]};
          `ACR_OFF_HI: rdata <= hi_r;
          `ACR_OFF_LO: rdata <= lo_r;
          default: rdata <= 32'h00000000;
        endcase
        if (!in_block)
          rdata <= 32'h00000000;
      end
    end
  end
endmodule // acr_ctrl

// ### hw/acr_regs.vh
// Register offsets, field positions, reset values and timing counts of the converter control block.
`ifndef ACR_REGS_VH
`define ACR_REGS_VH
`define ACR_BASE_ADDR 32'h40800000
`define ACR_OFF_CMD 8'h00
`define ACR_OFF_SET 8'h04
`define ACR_OFF_MSTAT 8'h08
`define ACR_OFF_MASK 8'h0C
`define ACR_OFF_RAW 8'h10
`define ACR_OFF_RES 8'h14
`define ACR_OFF_OFS 8'h18
`define ACR_OFF_STAT 8'h20
`define ACR_OFF_HI 8'h24
`define ACR_OFF_LO 8'h28
`define ACR_CMD_POWER 0
`define ACR_CMD_CALREQ 1
`define ACR_CMD_TRIG 2
`define ACR_CMD_SRST 3
`define ACR_CMD_STOP 4
`define ACR_CMD_WINEN 5
`define ACR_CMD_CALCAN 6
`define ACR_CMD_TRIM 7
`define ACR_CMD_MICPWR 8
`define ACR_CMD_DMAEN 9
`define ACR_CMD_MASKW 32'h000003FF
`define ACR_SET_CONT 11
`define ACR_SET_BYPASS 18
`define ACR_RST_CMD 32'h00000000
`define ACR_RST_SET 32'h0000000C
`define ACR_RST_MASK 32'h0000000F
`define ACR_RST_HI 32'h0FFFFFFF
`define ACR_RST_LO 32'h00000000
`define ACR_RST_OFS 32'h00000000
`define ACR_IRQ_EOC 0
`define ACR_IRQ_CAL 1
`define ACR_IRQ_WIN 2
`define ACR_ST_BUSY 3
`define ACR_WAKE_NS 6000
`define ACR_CLK_NS 10
`define ACR_WAKE_CYC ((`ACR_WAKE_NS + `ACR_CLK_NS - 1) / `ACR_CLK_NS)
`define ACR_ACQ_CYC 64
`define ACR_CAL_CYC 32
`endif

// ### hw/acr_window.v
// Window comparator: flags a value lying between the lower and upper limits.
`timescale 1ns/1ns
module acr_window
(
  // Operands.
  input wire [31:0] value,
  input wire [31:0] lower,
  input wire [31:0] upper,
  input wire enable,
  // Result.
  output wire hit
);
  // Signed compare since results are two's complement.
  assign hit = enable && ($signed(value) >= $signed(lower)) && ($signed(value) <= $signed(upper));
endmodule // acr_window
